// ### include/ngu_pkg.sv
`default_nettype none
package ngu_pkg;
	// ----------------------------------------
	// pins and link
	// ----------------------------------------
	localparam int unsigned NGU_PINS = 16;
	localparam logic [15:0] NGU_CTRL_PORT = 16'h1F90; // tcp port 8080
	localparam logic [15:0] NGU_ALL_ONES = 16'hFFFF;
	localparam logic [4:0] NGU_ITEM_FULL = 5'h10; // 16 digits
	localparam logic [4:0] NGU_ITEM_OVER = 5'h11;
	localparam logic [4:0] NGU_LEN_GROUP = 5'h10;
	localparam logic [4:0] NGU_LEN_SINGLE = 5'h01;
	localparam logic [2:0] NGU_TGT_OVER = 3'h7;
	localparam logic [1:0] NGU_DST_LEN = 2'h2;
	localparam logic [1:0] NGU_DST_OVER = 2'h3;
	localparam logic [1:0] NGU_TWO_WORDS = 2'h2;
	// ----------------------------------------
	// ascii codes
	// ----------------------------------------
	localparam logic [7:0] CH_NUL = 8'h00;
	localparam logic [7:0] CH_AMP = 8'h26;
	localparam logic [7:0] CH_SLASH = 8'h2F;
	localparam logic [7:0] CH_QMARK = 8'h3F;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_1 = 8'h31;
	localparam logic [7:0] CH_9 = 8'h39;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_F = 8'h46;
	localparam logic [7:0] CH_H = 8'h48;
	localparam logic [7:0] CH_L = 8'h4C;
	localparam logic [7:0] CH_P = 8'h50;
	localparam logic [7:0] CH_R = 8'h52;
	localparam logic [7:0] CH_U = 8'h55;
	localparam logic [7:0] CH_W = 8'h57;
	localparam logic [7:0] CH_X = 8'h58;
	localparam logic [7:0] CH_LOW_A = 8'h61;
	localparam logic [7:0] CH_LOW_Z = 8'h7A;
	localparam logic [7:0] CH_CASE = 8'h20;
	localparam logic [7:0] HEX_ALPHA_OFS = 8'h37; // 'A' - 10
	// target keywords, right aligned, upper case
	localparam logic [47:0] KW_PINS = 48'h0000_4750_494F;
	localparam logic [47:0] KW_I2C = 48'h0000_0049_3243;
	localparam logic [47:0] KW_EEPROM = 48'h4545_5052_4F4D;
	localparam logic [2:0] KW_PINS_LEN = 3'h4;
	localparam logic [2:0] KW_I2C_LEN = 3'h3;
	localparam logic [2:0] KW_EEPROM_LEN = 3'h6;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_DIR = 8'h04;
	localparam logic [7:0] REG_ALT = 8'h08;
	localparam logic [7:0] REG_PROT = 8'h0C;
	localparam logic [7:0] REG_OUT = 8'h10;
	localparam logic [7:0] REG_IN = 8'h14;
	localparam logic [7:0] REG_STAT = 8'h18;
	localparam int unsigned CTRL_NET_EN = 0; // accept network requests
	localparam int unsigned CTRL_NET_WR = 1; // allow network writes
	localparam logic [15:0] CTRL_RESET = 16'h0003;
	localparam logic [15:0] PINREG_RESET = 16'h0000;
	localparam int unsigned STAT_ERR = 0;
	localparam int unsigned STAT_BUSY = 1;
	localparam int unsigned STAT_CNT_LSB = 16;
	// ----------------------------------------
	// result placement
	// ----------------------------------------
	localparam logic [1:0] PLACE_HDR = 2'h0;
	localparam logic [1:0] PLACE_META = 2'h1;
	localparam logic [1:0] PLACE_DIV = 2'h2;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_TGT = 7'h02,
		ST_DST = 7'h04,
		ST_DATA = 7'h08,
		ST_FIN = 7'h10,
		ST_EXEC = 7'h20,
		ST_SEND = 7'h40
	} ngu_state_t;
endpackage
`default_nettype wire

// ### rtl/ngu_uri_gpio.sv
`timescale 1ns/100ps
`default_nettype none
module ngu_uri_gpio (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [7:0] req_char,
	input wire logic req_last,
	input wire logic [15:0] req_port,
	output logic res_valid,
	input wire logic res_ready,
	output logic [7:0] res_char,
	output logic [1:0] res_place,
	output logic res_last,
	output logic res_err,
	input wire logic [ngu_pkg::NGU_PINS-1:0] pin_i,
	output logic [ngu_pkg::NGU_PINS-1:0] pin_o,
	output logic [ngu_pkg::NGU_PINS-1:0] pin_oe
);
	import ngu_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] to_upper(input logic [7:0] c);
		to_upper = (c >= CH_LOW_A && c <= CH_LOW_Z) ? (c & ~CH_CASE) : c;
	endfunction

	function automatic logic hex_ok(input logic [7:0] c);
		hex_ok = (c >= CH_0 && c <= CH_9) || (c >= CH_A && c <= CH_F);
	endfunction

	function automatic logic [3:0] hex_val(input logic [7:0] c);
		logic [7:0] v;
		v = (c <= CH_9) ? (c - CH_0) : (c - HEX_ALPHA_OFS);
		hex_val = v[3:0];
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// result character for one pin
	function automatic logic [7:0] pin_char(input logic d, input logic a, input logic p, input logic o,
			input logic i);
		if (a) begin
			pin_char = CH_U;
		end else if (p) begin
			pin_char = CH_P;
		end else if (d) begin
			pin_char = o ? CH_1 : CH_0;
		end else begin
			pin_char = i ? CH_H : CH_L;
		end
	endfunction

	ngu_state_t state;
	logic [15:0] ctrl;
	logic [15:0] dir;
	logic [15:0] alt;
	logic [15:0] prot;
	logic [15:0] out_r;
	logic [15:0] pin_meta;
	logic [15:0] pin_sync;
	logic [15:0] req_cnt;
	logic last_err;
	logic wb_hit;
	logic take;
	logic [7:0] c_up;
	logic [47:0] tgt_buf;
	logic [2:0] tgt_len;
	logic [15:0] dst_buf;
	logic [1:0] dst_len;
	logic [4:0] it_len;
	logic [15:0] it_bits;
	logic it_bin;
	logic [7:0] it_ch;
	logic [1:0] item_no;
	logic in_data;
	logic bad;
	logic port_ok;
	logic grp_w;
	logic [1:0] grp_cnt;
	logic [15:0] word0;
	logic [15:0] word1;
	logic sgl_w;
	logic sgl_v;
	logic grp;
	logic sgl_ok;
	logic [3:0] sgl_pin;
	logic tgt_pins;
	logic tgt_known;
	logic it_rw;
	logic it_word;
	logic it_sgl;
	logic close_item;
	logic exec_bad;
	logic wr_req;
	logic [15:0] sel;
	logic [15:0] val;
	logic [15:0] allow;
	logic net_wr;
	logic [15:0] net_out;
	logic [7:0] first_ch;
	logic item_bad;
	logic [7:0] res_mem [0:15];
	logic [4:0] res_len;
	logic [4:0] idx;
	logic place_end;

	// ----------------------------------------
	// pin side
	// ----------------------------------------
	// two stage synchroniser on the pin inputs
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pin_meta <= PINREG_RESET;
			pin_sync <= PINREG_RESET;
		end else begin
			pin_meta <= pin_i;
			pin_sync <= pin_meta;
		end
	end

	// drive only general purpose output pins
	// alternate pins undriven
	assign pin_o = out_r;
	assign pin_oe = dir & ~alt;

	// ----------------------------------------
	// request decode
	// ----------------------------------------
	assign take = req_valid & req_ready;
	assign c_up = to_upper(req_char);
	assign req_ready = (state == ST_IDLE) || (state == ST_TGT) || (state == ST_DST) || (state == ST_DATA);

	assign tgt_pins = (tgt_len == KW_PINS_LEN) && (tgt_buf == KW_PINS);
	assign tgt_known = tgt_pins || ((tgt_len == KW_I2C_LEN) && (tgt_buf == KW_I2C))
		|| ((tgt_len == KW_EEPROM_LEN) && (tgt_buf == KW_EEPROM));
	assign grp = (dst_len == NGU_DST_LEN) && (dst_buf == {CH_0, CH_X});
	assign sgl_ok = (dst_len == NGU_DST_LEN) && (dst_buf[15:8] == CH_0) && hex_ok(dst_buf[7:0]);
	assign sgl_pin = hex_val(dst_buf[7:0]);

	// item classification when an item closes
	// optional direction letter
	assign it_rw = grp && (item_no == 2'h0) && (it_len == NGU_LEN_SINGLE) && ((it_ch == CH_R) || (it_ch == CH_W));
	assign it_word = grp && (it_len == NGU_ITEM_FULL) && it_bin;
	assign it_sgl = !grp && (item_no == 2'h0) && (it_len == NGU_LEN_SINGLE) && it_bin;
	assign close_item = (state == ST_DATA && take && c_up == CH_AMP) || (state == ST_FIN && in_data);
	// malformed item, also when closed by an ampersand
	assign item_bad = close_item && (!(it_rw || it_word || it_sgl) || (it_word && grp_cnt == NGU_TWO_WORDS));

	// next state
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE, ST_TGT, ST_DST, ST_DATA: begin
					if (take && req_last) begin
						state <= ST_FIN;
					end else if (take && state == ST_IDLE) begin
						state <= ST_TGT;
					end else if (take && c_up == CH_SLASH && state == ST_TGT) begin
						state <= ST_DST;
					end else if (take && c_up == CH_QMARK && state != ST_DATA) begin
						state <= ST_DATA;
					end
				end
				ST_FIN: state <= ST_EXEC;
				ST_EXEC: state <= ST_SEND;
				ST_SEND: begin
					if (res_ready && res_last) begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// parser fields
	// ----------------------------------------
	// fields collected in path order
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			tgt_buf <= '0;
			tgt_len <= '0;
			dst_buf <= '0;
			dst_len <= '0;
			in_data <= 1'b0;
			bad <= 1'b0;
			port_ok <= 1'b0;
		end else if (take && state == ST_IDLE) begin
			tgt_buf <= '0;
			tgt_len <= '0;
			dst_buf <= '0;
			dst_len <= '0;
			in_data <= 1'b0;
			port_ok <= (req_port == NGU_CTRL_PORT);
			bad <= (c_up != CH_SLASH);
		end else if (take) begin
			if (state == ST_TGT && c_up != CH_SLASH && c_up != CH_QMARK) begin
				tgt_buf <= {tgt_buf[39:0], c_up};
				tgt_len <= (tgt_len == NGU_TGT_OVER) ? tgt_len : tgt_len + 3'h1;
			end
			if (state == ST_DST && c_up == CH_SLASH) begin
				bad <= 1'b1;
			end else if (state == ST_DST && c_up != CH_QMARK) begin
				dst_buf <= {dst_buf[7:0], c_up};
				dst_len <= (dst_len == NGU_DST_OVER) ? dst_len : dst_len + 2'h1;
			end
			if (c_up == CH_QMARK && state != ST_DATA) begin
				in_data <= 1'b1;
			end
			if (state == ST_DATA && (c_up == CH_QMARK || c_up == CH_SLASH)) begin
				bad <= 1'b1;
			end
			if (item_bad) begin
				bad <= 1'b1;
			end
		end else if (item_bad) begin
			bad <= 1'b1;
		end
	end

	// data items
	// split at ampersand
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			it_len <= '0;
			it_bits <= '0;
			it_bin <= 1'b1;
			it_ch <= CH_NUL;
			item_no <= '0;
			grp_w <= 1'b0;
			grp_cnt <= '0;
			word0 <= '0;
			word1 <= '0;
			sgl_w <= 1'b0;
			sgl_v <= 1'b0;
		end else if ((take && state == ST_IDLE) || close_item) begin
			it_len <= '0;
			it_bits <= '0;
			it_bin <= 1'b1;
			it_ch <= CH_NUL;
			if (take && state == ST_IDLE) begin
				item_no <= '0;
				grp_w <= 1'b0;
				grp_cnt <= '0;
				sgl_w <= 1'b0;
			end else begin
				item_no <= (item_no == 2'h3) ? item_no : item_no + 2'h1;
				if (it_rw) begin
					grp_w <= (it_ch == CH_W);
				end
				// first digit lands in bit 15
				if (it_word && grp_cnt == 2'h0) begin
					word0 <= it_bits;
				end
				if (it_word && grp_cnt == 2'h1) begin
					word1 <= it_bits;
				end
				if (it_word && grp_cnt != NGU_TWO_WORDS) begin
					grp_cnt <= grp_cnt + 2'h1;
				end
				if (it_sgl) begin
					sgl_w <= 1'b1;
					sgl_v <= it_bits[0];
				end
			end
		end else if (take && state == ST_DATA) begin
			it_len <= (it_len == NGU_ITEM_OVER) ? it_len : it_len + 5'h01;
			it_bits <= {it_bits[14:0], c_up == CH_1};
			it_bin <= it_bin && (c_up == CH_0 || c_up == CH_1);
			if (it_len == 5'h00) begin
				it_ch <= c_up;
			end
		end
	end

	// ----------------------------------------
	// execution
	// ----------------------------------------
	// reject malformed or foreign requests
	// destination and data interpreted per pin target
	always_comb begin
		exec_bad = bad || !port_ok || !ctrl[CTRL_NET_EN] || !tgt_known || !(grp || sgl_ok);
		// other targets not served here fail
		if (!tgt_pins) begin
			exec_bad = 1'b1;
		end
		if (grp && grp_w && grp_cnt == 2'h0) begin
			exec_bad = 1'b1;
		end
		if (grp && !grp_w && grp_cnt == NGU_TWO_WORDS) begin
			exec_bad = 1'b1;
		end
	end

	assign wr_req = grp ? grp_w : sgl_w;
	assign sel = grp ? ((grp_cnt == NGU_TWO_WORDS) ? word0 : NGU_ALL_ONES) : (16'h0001 << sgl_pin);
	assign val = grp ? ((grp_cnt == NGU_TWO_WORDS) ? word1 : word0) : {NGU_PINS{sgl_v}};
	assign allow = sel & ~alt & ~prot;
	// latch after a network write, also feeds the report
	// network write gate
	assign net_wr = (state == ST_EXEC) && !exec_bad && wr_req && ctrl[CTRL_NET_WR];
	assign net_out = net_wr ? ((out_r & ~allow) | (val & allow)) : out_r;

	// ----------------------------------------
	// wishbone registers
	// ----------------------------------------
	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

	// configuration and output latch
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= CTRL_RESET;
			dir <= PINREG_RESET;
			alt <= PINREG_RESET;
			prot <= PINREG_RESET;
			out_r <= PINREG_RESET;
		end else begin
			// bus write lands at the acknowledge edge
			if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
				case (wb_adr_i)
					REG_CTRL: ctrl <= merge16(ctrl, wb_dat_i, wb_sel_i);
					REG_DIR: dir <= merge16(dir, wb_dat_i, wb_sel_i);
					REG_ALT: alt <= merge16(alt, wb_dat_i, wb_sel_i);
					REG_PROT: prot <= merge16(prot, wb_dat_i, wb_sel_i);
					REG_OUT: out_r <= merge16(out_r, wb_dat_i, wb_sel_i);
					default: ;
				endcase
			end
			if (net_wr) begin
				out_r <= net_out;
			end
		end
	end

	// read mux and acknowledge, one wait cycle
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_hit;
			if (wb_hit) begin
				case (wb_adr_i)
					REG_CTRL: wb_dat_o <= {16'h0000, ctrl};
					REG_DIR: wb_dat_o <= {16'h0000, dir};
					REG_ALT: wb_dat_o <= {16'h0000, alt};
					REG_PROT: wb_dat_o <= {16'h0000, prot};
					REG_OUT: wb_dat_o <= {16'h0000, out_r};
					REG_IN: wb_dat_o <= {16'h0000, pin_sync};
					REG_STAT: wb_dat_o <= {req_cnt, 14'h0000, state != ST_IDLE, last_err};
					default: wb_dat_o <= '0;
				endcase
			end
		end
	end

	// request counter and last status
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			req_cnt <= '0;
			last_err <= 1'b0;
		end else if (state == ST_EXEC) begin
			req_cnt <= req_cnt + 16'h0001;
			last_err <= exec_bad;
		end
	end

	// ----------------------------------------
	// result stream
	// ----------------------------------------
	// result captured at the write edge from net_out so it shows pin state afterwards
	// output reports 0 or 1 unless alternate or protected
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NGU_PINS; i++) begin
				res_mem[i] <= CH_NUL;
			end
			res_len <= NGU_LEN_SINGLE;
		end else if (state == ST_EXEC) begin
			res_len <= grp ? NGU_LEN_GROUP : NGU_LEN_SINGLE;
			for (int i = 0; i < NGU_PINS; i++) begin
				res_mem[i] <= grp ? pin_char(dir[NGU_PINS-1-i], alt[NGU_PINS-1-i], prot[NGU_PINS-1-i],
					net_out[NGU_PINS-1-i], pin_sync[NGU_PINS-1-i]) : CH_NUL;
			end
			if (!grp) begin
				res_mem[0] <= first_ch;
			end
		end
	end

	// first beat character, ready when the answer opens
	assign first_ch = grp ? pin_char(dir[NGU_PINS-1], alt[NGU_PINS-1], prot[NGU_PINS-1], net_out[NGU_PINS-1],
		pin_sync[NGU_PINS-1]) : pin_char(dir[sgl_pin], alt[sgl_pin], prot[sgl_pin], net_out[sgl_pin],
		pin_sync[sgl_pin]);

	assign place_end = res_err || (idx == res_len - 5'h01);
	assign res_valid = (state == ST_SEND);
	assign res_last = res_valid && place_end && (res_err || res_place == PLACE_DIV);

	// walk index and place, character register
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			idx <= '0;
			res_place <= PLACE_HDR;
			res_char <= CH_NUL;
			res_err <= 1'b0;
		end else if (state == ST_EXEC) begin
			idx <= '0;
			res_place <= PLACE_HDR;
			res_err <= exec_bad;
			res_char <= exec_bad ? CH_NUL : first_ch;
		end else if (state == ST_SEND && res_ready && !res_last) begin
			if (place_end) begin
				idx <= '0;
				res_place <= (res_place == PLACE_HDR) ? PLACE_META : PLACE_DIV;
				res_char <= res_mem[0];
			end else begin
				idx <= idx + 5'h01;
				res_char <= res_mem[idx[3:0] + 4'h1];
			end
		end else if (state == ST_SEND && idx == 5'h00 && !res_err) begin
			res_char <= res_mem[0];
		end
	end
endmodule
`default_nettype wire

// ### sim/ngu_uri_gpio_properties.sv
`timescale 1ns/100ps
`default_nettype none
module ngu_uri_gpio_properties (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic req_last,
	input wire logic res_valid,
	input wire logic res_ready,
	input wire logic [7:0] res_char,
	input wire logic [1:0] res_place,
	input wire logic res_last,
	input wire logic res_err,
	input wire logic [ngu_pkg::NGU_PINS-1:0] pin_o,
	input wire logic [ngu_pkg::NGU_PINS-1:0] pin_oe
);
	import ngu_pkg::*;
	// ----------------------------------------
	// clocking and helpers
	// ----------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	// bus write seen at an edge
	logic bus_wr;
	assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i;
	// two quiet cycles, then the answer
	sequence s_quiet2;
		(!res_valid && !req_ready) [*2];
	endsequence
	sequence s_answer;
		s_quiet2 ##1 res_valid;
	endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not acknowledged next cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge longer than one cycle");
	a_answer_delay: assert property (req_valid && req_ready && req_last |=> s_answer)
		else $error("answer not three cycles after last char");
	a_busy_refuse: assert property (res_valid |-> !req_ready)
		else $error("request char accepted during answer");
	a_beat_hold: assert property (res_valid && !res_ready |=> res_valid && $stable({res_char, res_place, res_err}))
		else $error("answer beat changed while stalled");
	a_err_beat: assert property (res_valid && res_err |-> res_last && res_char == CH_NUL && res_place == PLACE_HDR)
		else $error("error answer not a single status beat");
	a_last_div: assert property (res_valid && res_last && !res_err |-> res_place == PLACE_DIV)
		else $error("answer does not end in body place");
	a_place_step: assert property (res_valid && res_ready && !res_last |=>
		res_valid && (res_place == $past(res_place) || res_place == $past(res_place) + 2'h1))
		else $error("answer places out of order");
	a_oe_cause: assert property ($changed(pin_oe) |-> $past(bus_wr))
		else $error("output enables changed without bus write");
	a_pin_cause: assert property ($changed(pin_o) |-> $past(bus_wr) || $rose(res_valid))
		else $error("pin latch changed without a cause");
endmodule
`default_nettype wire

// ### sim/ngu_client_model.sv
`timescale 1ns/100ps
`default_nettype none
module ngu_client_model (
	input wire logic sys_clk,
	output logic req_valid,
	input wire logic req_ready,
	output logic [7:0] req_char,
	output logic req_last,
	output logic [15:0] req_port,
	input wire logic res_valid,
	output logic res_ready,
	input wire logic [7:0] res_char,
	input wire logic [1:0] res_place,
	input wire logic res_last,
	input wire logic res_err
);
	int slow = 0;
	int tick = 0;
	logic [10:0] got [$];
	// idle levels before the first request
	initial begin
		req_valid = 1'b0;
		req_char = 8'hFF;
		req_last = 1'b0;
		req_port = 16'h0000;
		res_ready = 1'b1;
	end
	// answer intake, stalling two cycles of three when slow
	always @(posedge sys_clk) begin
		tick <= tick + 1;
		res_ready <= slow == 0 || tick % 3 == 0;
		if (res_valid && res_ready)
			got.push_back({res_err, res_place, res_char});
	end
	task automatic send(input string s, input logic [15:0] p);
		@(posedge sys_clk);
		for (int i = 0; i < s.len(); i++) begin
			req_valid <= 1'b1;
			req_char <= s[i];
			req_last <= i == s.len() - 1;
			req_port <= p;
			do
				@(posedge sys_clk);
			while (req_ready !== 1'b1);
		end
		req_valid <= 1'b0;
		req_last <= 1'b0;
		req_char <= ~s[s.len() - 1];
		req_port <= ~p;
	endtask
endmodule
`default_nettype wire

// ### sim/network_gpio_uri_command_test.sv
`timescale 1ns/100ps
`default_nettype none
module network_gpio_uri_command_test;
	import ngu_pkg::*;
	// ----------------------------------------
	// signals and model state
	// ----------------------------------------
	localparam int ALL = 32'h0000_FFFF;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o, rd;
	logic wb_ack_o, req_valid, req_ready, req_last, res_valid, res_ready, res_last, res_err;
	logic [7:0] req_char, res_char;
	logic [15:0] req_port, pin_o, pin_oe;
	logic [15:0] pin_i = 16'h0000;
	logic [1:0] res_place;
	int failures = 0;
	int n_checks = 0;
	int n_req = 0;
	int seed = 12189;
	int ctrl = 3, dir, alt, prot, outv;
	string bad [7] = '{"/I2C?0400", "/EEPROM/0D", "/FOO", "/GPIO/10", "/GPIO/0G", "/GPIO/0X?W&0101&1111111111111111",
		"/GPIO/00?1&1"};
	// clock
	always #25 sys_clk = ~sys_clk;
	// ----------------------------------------
	// design and far-side client
	// ----------------------------------------
	ngu_uri_gpio ngu_uri_gpio_i (.sys_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .req_valid, .req_ready, .req_char, .req_last, .req_port, .res_valid, .res_ready,
		.res_char, .res_place, .res_last, .res_err, .pin_i, .pin_o, .pin_oe);
	ngu_client_model cli (.sys_clk, .req_valid, .req_ready, .req_char, .req_last, .req_port, .res_valid,
		.res_ready, .res_char, .res_place, .res_last, .res_err);
	// ----------------------------------------
	// compare, bus and request tasks
	// ----------------------------------------
	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_beat(input logic [10:0] g, input logic [10:0] e);
		chk_word({21'h00_0000, g}, {21'h00_0000, e});
	endtask
	// one classic cycle, waiting for the acknowledge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'h3;
		do
			@(posedge sys_clk);
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// expected report character of one pin
	function automatic logic [7:0] ec(int i);
		if (alt[i])
			return CH_U;
		if (prot[i])
			return CH_P;
		if (dir[i])
			return outv[i] ? CH_1 : CH_0;
		return pin_i[i] ? CH_H : CH_L;
	endfunction
	// send a path, update the model, compare every beat and the pins
	task automatic run(input string p, input logic [15:0] pn, input int err, input int m, input int v, input int one);
		logic [7:0] ex [$];
		int sel, cnt;
		sel = m & ~alt & ~prot & (ctrl[1] ? ALL : 0);
		if (err == 0)
			outv = (outv & ~sel) | (v & sel);
		for (int i = 15; i >= 0; i--)
			if (one < 0 || one == i)
				ex.push_back(ec(i));
		cnt = err ? 1 : 3 * ex.size();
		cli.got.delete();
		cli.send(p, pn);
		n_req++;
		for (int n = 0; n < 2000 && cli.got.size() < cnt; n++)
			@(posedge sys_clk);
		repeat (2) @(posedge sys_clk);
		chk_word(cli.got.size(), cnt);
		for (int k = 0; k < cnt; k++)
			chk_beat(cli.got[k], err ? {1'b1, PLACE_HDR, CH_NUL} : {1'b0, 2'(k / ex.size()), ex[k % ex.size()]});
		chk_word(pin_o, outv & ALL);
		chk_word(pin_oe, dir & ~alt & ALL);
	endtask
	task automatic end_of_test();
		if (failures == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		int b, m, v;
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		wb(1'b1, 8'h1C, 32'hFFFF_FFFF);
		wb(1'b1, REG_IN, 32'h0000_FFFF);
		for (int a = 0; a < 8; a++) begin
			wb(1'b0, 8'(a * 4), 32'h0000_0000);
			chk_word(rd, a == 0 ? 32'h0000_0003 : 32'h0000_0000);
		end
		dir = $random(seed) & ALL;
		alt = $random(seed) & $random(seed) & 32'h0000_F0F0;
		prot = $random(seed) & $random(seed) & ALL;
		outv = $random(seed) & ALL;
		pin_i <= 16'($random(seed));
		wb(1'b1, REG_DIR, dir);
		wb(1'b1, REG_ALT, alt);
		wb(1'b1, REG_PROT, prot);
		wb(1'b1, REG_OUT, outv);
		wb(1'b0, REG_IN, 32'h0000_0000);
		chk_word(rd, {16'h0000, pin_i});
		for (int i = 0; i < 16; i++) begin
			b = $random(seed) & 1;
			run($sformatf("/GPIO/%02h", i), NGU_CTRL_PORT, 0, 0, 0, i);
			run($sformatf("/gpio/%02h?%0d", i, b), NGU_CTRL_PORT, 0, 1 << i, b << i, i);
		end
		cli.slow = 1;
		m = $random(seed);
		v = $random(seed);
		run("/GPIO/0X", NGU_CTRL_PORT, 0, 0, 0, -1);
		run($sformatf("/gpio/0x?r&%016b", m[15:0]), NGU_CTRL_PORT, 0, 0, 0, -1);
		run($sformatf("/GPIO/0X?W&%016b&%016b", m[15:0], v[15:0]), NGU_CTRL_PORT, 0, m, v, -1);
		run($sformatf("/GPIO/0x?w&%016b", ~v[15:0]), NGU_CTRL_PORT, 0, ALL, ~v, -1);
		ctrl = 1;
		wb(1'b1, REG_CTRL, ctrl);
		run($sformatf("/GPIO/0X?W&%016b", v[15:0]), NGU_CTRL_PORT, 0, ALL, v, -1);
		ctrl = 3;
		wb(1'b1, REG_CTRL, ctrl);
		pin_i <= ~pin_i;
		repeat (3) @(posedge sys_clk);
		run("/GPIO/0X", NGU_CTRL_PORT, 0, 0, 0, -1);
		foreach (bad[i])
			run(bad[i], NGU_CTRL_PORT, 1, ALL, 0, -1);
		run("/GPIO/00?1", NGU_CTRL_PORT + 16'h0001, 1, 1, 1, 0);
		ctrl = 2;
		wb(1'b1, REG_CTRL, ctrl);
		run("/GPIO/00?1", NGU_CTRL_PORT, 1, 1, 1, 0);
		wb(1'b0, REG_STAT, 32'h0000_0000);
		chk_word(rd, {n_req[15:0], 16'h0001});
		end_of_test();
	end
	// hang guard, far beyond the few thousand cycles expected
	initial begin
		repeat (30000) @(posedge sys_clk);
		failures++;
		end_of_test();
	end
endmodule
bind ngu_uri_gpio ngu_uri_gpio_properties ngu_uri_gpio_properties_i (.sys_clk, .nrst, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_ack_o, .req_valid, .req_ready, .req_last, .res_valid, .res_ready, .res_char, .res_place,
	.res_last, .res_err, .pin_o, .pin_oe);
`default_nettype wire
